// File: hw/tkpm_defines.svh
`ifndef TKPM_DEFINES_SVH
`define TKPM_DEFINES_SVH
// Number of shared key/status pins and dedicated key inputs.
`define TKPM_SHARED_KEYS 9
`define TKPM_TOUCH_KEYS 9
// Settle time after reset release before the straps are caught, in ns.
`define TKPM_STRAP_SETTLE_NS 100
`define TKPM_CLK_PERIOD_NS 10
`define TKPM_STRAP_SETTLE_CYC ((`TKPM_STRAP_SETTLE_NS + `TKPM_CLK_PERIOD_NS - 1) / `TKPM_CLK_PERIOD_NS)
// Reset value of the packet request pin: high means idle and ready.
`define TKPM_REQ_IDLE 1'b1
// Field positions of the three select straps in the captured code.
`define TKPM_SEL0_BIT 0
`define TKPM_SEL1_BIT 1
`define TKPM_SEL2_BIT 2
`endif

// File: hw/tkpm_pkg.sv
`default_nettype none
package tkpm_pkg;
  // Which serial slave the strap code selected; the code mapping is external.
  typedef enum logic [1:0]
  {
    TKPM_LINK_NONE = 2'b00,
    TKPM_LINK_I2C = 2'b01,
    TKPM_LINK_SPI = 2'b10
  } tkpm_link_t;
  // Strap capture sequence after reset.
  typedef enum logic [1:0]
  {
    TKPM_ST_SETTLE = 2'b00,
    TKPM_ST_CAPTURE = 2'b01,
    TKPM_ST_RUN = 2'b10
  } tkpm_state_t;
endpackage : tkpm_pkg
`default_nettype wire

// File: hw/tkpm_pin_mode_select.sv
`include "tkpm_defines.svh"
`default_nettype none
module tkpm_pin_mode_select #(
  parameter int SHARED_KEYS = `TKPM_SHARED_KEYS,
  parameter int TOUCH_KEYS = `TKPM_TOUCH_KEYS
)
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Pin straps and asynchronous pin inputs.
  input wire logic i_pin_mode_select,
  input wire logic i_power_save_n,
  input wire logic i_interface_select_0,
  input wire logic i_interface_select_1,
  input wire logic i_interface_select_2,
  input wire logic [TOUCH_KEYS-1:0] i_touch_key_inputs,
  input wire logic [SHARED_KEYS-1:0] i_shared_key_or_status_pins,
  // Decoding of the strap code is supplied by the core; it says SPI when high.
  input wire logic i_strap_means_spi,
  // Core side: packet pending flag, serial out data and I2C data drive-low.
  input wire logic i_packet_pending,
  input wire logic i_spi_data_out,
  input wire logic i_i2c_data_drive_low,
  // Core asks shared pins to act as status outputs in this operating mode.
  input wire logic i_shared_as_status,
  input wire logic [SHARED_KEYS-1:0] i_key_status,
  // Pin outputs.
  output logic o_packet_request_n,
  output logic o_interface_select_1,
  output logic o_interface_select_1_oe,
  output logic o_interface_select_2,
  output logic o_interface_select_2_oe,
  output logic [SHARED_KEYS-1:0] o_shared_key_or_status_pins,
  output logic [SHARED_KEYS-1:0] o_shared_key_or_status_pins_oe,
  // Core side results.
  output logic o_protocol_mode,
  output logic o_sleep,
  output logic [1:0] o_link_kind,
  output logic o_serial_clk,
  output logic o_serial_data_in,
  output logic [2:0] o_direct_mode_code,
  output logic [TOUCH_KEYS+SHARED_KEYS-1:0] o_keys,
  output logic o_ready
);
  localparam int NSYNC = 5 + TOUCH_KEYS + SHARED_KEYS;
  localparam int SETTLE = `TKPM_STRAP_SETTLE_CYC;
  // Levels the pins are taken to have while the synchroniser fills. The power-save pin
  // idles high, so the block must not report a false sleep just after reset.
  localparam logic [NSYNC-1:0] IDLE_LEVELS = {{(NSYNC-4){1'b0}}, 4'h8};

  // Three-stage synchronisers; stage 1 is read only by stage 2.
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;
  logic [NSYNC-1:0] sync3_r;
  // Debounced view: updated once stages 2 and 3 agree.
  logic [NSYNC-1:0] clean_r;
  logic [NSYNC-1:0] raw_in;

  // Pack every outside input so one synchroniser array serves them all.
  always_comb
  begin
    raw_in = {i_shared_key_or_status_pins, i_touch_key_inputs, i_pin_mode_select,
              i_power_save_n, i_interface_select_2, i_interface_select_1,
              i_interface_select_0};
  end

  // Synchroniser chain; resets to the idle levels so no false change follows reset.
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      sync1_r <= IDLE_LEVELS;
      sync2_r <= IDLE_LEVELS;
      sync3_r <= IDLE_LEVELS;
    end
    else
    begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // Accept a bit change only when stages 2 and 3 agree, filtering one-cycle glitches.
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      clean_r <= IDLE_LEVELS;
    end
    else
    begin
      for (int i = 0; i < NSYNC; i++)
      begin
        if (sync2_r[i] == sync3_r[i])
        begin
          clean_r[i] <= sync3_r[i];
        end
      end
    end
  end

  // Strap capture sequence.
  tkpm_pkg::tkpm_state_t state_r;
  logic [7:0] settle_r;
  logic protocol_r;
  tkpm_pkg::tkpm_link_t link_r;

  // The mode strap and link choice are caught once, after the pipeline has filled, then frozen.
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      state_r <= tkpm_pkg::TKPM_ST_SETTLE;
      settle_r <= 8'h00;
      protocol_r <= 1'b0;
      link_r <= tkpm_pkg::TKPM_LINK_NONE;
    end
    else
    begin
      unique case (state_r)
        tkpm_pkg::TKPM_ST_SETTLE:
        begin
          // Wait for synchroniser fill plus settle time so straps are stable.
          if (settle_r >= 8'(SETTLE + 4))
          begin
            state_r <= tkpm_pkg::TKPM_ST_CAPTURE;
          end
          else
          begin
            settle_r <= settle_r + 8'h01;
          end
        end
        tkpm_pkg::TKPM_ST_CAPTURE:
        begin
          protocol_r <= ~clean_r[4];
          if (!clean_r[4])
          begin
            link_r <= i_strap_means_spi ? tkpm_pkg::TKPM_LINK_SPI
                                        : tkpm_pkg::TKPM_LINK_I2C;
          end
          state_r <= tkpm_pkg::TKPM_ST_RUN;
        end
        tkpm_pkg::TKPM_ST_RUN:
        begin
          // Held until the next reset, whatever the straps do now.
          state_r <= tkpm_pkg::TKPM_ST_RUN;
        end
        default:
        begin
          state_r <= tkpm_pkg::TKPM_ST_SETTLE;
        end
      endcase
    end
  end

  logic run;
  logic is_spi;
  logic is_i2c;
  always_comb
  begin
    run = (state_r == tkpm_pkg::TKPM_ST_RUN);
    is_spi = run && protocol_r && (link_r == tkpm_pkg::TKPM_LINK_SPI);
    is_i2c = run && protocol_r && (link_r == tkpm_pkg::TKPM_LINK_I2C);
  end

  // Request pin and sleep state; request idles high so the host sees ready.
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_packet_request_n <= `TKPM_REQ_IDLE;
      o_sleep <= 1'b0;
      o_ready <= 1'b0;
      o_protocol_mode <= 1'b0;
      o_link_kind <= 2'b00;
    end
    else
    begin
      // Low only while a packet waits in protocol mode.
      o_packet_request_n <= ~(run && protocol_r && i_packet_pending);
      o_sleep <= ~clean_r[3];
      o_ready <= run;
      o_protocol_mode <= run && protocol_r;
      o_link_kind <= run ? link_r : tkpm_pkg::TKPM_LINK_NONE;
    end
  end

  // Select pin reuse: serial clock and data in protocol mode, mode code otherwise.
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_serial_clk <= 1'b1;
      o_serial_data_in <= 1'b1;
      o_direct_mode_code <= 3'h0;
      o_interface_select_1 <= 1'b0;
      o_interface_select_1_oe <= 1'b0;
      o_interface_select_2 <= 1'b0;
      o_interface_select_2_oe <= 1'b0;
    end
    else
    begin
      o_serial_clk <= (is_spi || is_i2c) ? clean_r[`TKPM_SEL0_BIT] : 1'b1;
      o_serial_data_in <= (is_spi || is_i2c) ? clean_r[`TKPM_SEL1_BIT] : 1'b1;
      // Open-drain I2C data: only ever pulled low, never driven high.
      o_interface_select_1 <= 1'b0;
      o_interface_select_1_oe <= is_i2c && i_i2c_data_drive_low;
      o_interface_select_2 <= is_spi ? i_spi_data_out : 1'b0;
      o_interface_select_2_oe <= is_spi;
      if (run && !protocol_r)
      begin
        o_direct_mode_code <= clean_r[2:0];
      end
      else
      begin
        o_direct_mode_code <= 3'h0;
      end
    end
  end

  // Shared pins: keys when inputs, status outputs when the mode asks for it.
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_shared_key_or_status_pins <= '0;
      o_shared_key_or_status_pins_oe <= '0;
      o_keys <= '0;
    end
    else
    begin
      if (run && i_shared_as_status)
      begin
        o_shared_key_or_status_pins <= i_key_status;
        o_shared_key_or_status_pins_oe <= {SHARED_KEYS{1'b1}};
        o_keys <= {{SHARED_KEYS{1'b0}}, clean_r[5 +: TOUCH_KEYS]};
      end
      else
      begin
        o_shared_key_or_status_pins <= '0;
        o_shared_key_or_status_pins_oe <= '0;
        o_keys <= clean_r[5 +: TOUCH_KEYS + SHARED_KEYS];
      end
    end
  end
endmodule : tkpm_pin_mode_select
`default_nettype wire

// File: tb/tkpm_properties.sv
`default_nettype none
module tkpm_properties (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_power_save_n,
  input wire logic i_packet_pending,
  input wire logic o_packet_request_n,
  input wire logic o_interface_select_1,
  input wire logic o_interface_select_1_oe,
  input wire logic o_interface_select_2_oe,
  input wire logic o_protocol_mode,
  input wire logic o_sleep,
  input wire logic [1:0] o_link_kind,
  input wire logic [2:0] o_direct_mode_code,
  input wire logic o_ready
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  // Eight steady samples cover the synchroniser and filter delay.
  sequence ps_low;
    !i_power_save_n [*8];
  endsequence
  sequence ps_high;
    i_power_save_n [*8];
  endsequence
  req_low_a: assert property (
    o_ready && o_protocol_mode && i_packet_pending |=> !o_packet_request_n)
    else $error("request stuck high");
  req_high_a: assert property (!i_packet_pending |=> o_packet_request_n)
    else $error("request low idle");
  proto_mode_a: assert property (
    o_ready && o_protocol_mode |-> o_direct_mode_code == 3'h0)
    else $error("code in protocol mode");
  direct_mode_a: assert property (
    o_ready && !o_protocol_mode |-> o_link_kind == 2'h0)
    else $error("link in direct mode");
  sleep_on_a: assert property (ps_low |-> o_sleep) else $error("no sleep");
  sleep_off_a: assert property (ps_high |-> !o_sleep) else $error("no wake");
  pre_ready_a: assert property (
    !o_ready |-> o_packet_request_n && !o_interface_select_2_oe)
    else $error("drive before ready");
  sda_drive_a: assert property (
    o_interface_select_1_oe |-> o_link_kind == 2'h1 && !o_interface_select_1)
    else $error("bad data drive");
  sdo_drive_a: assert property (
    o_interface_select_2_oe |-> o_link_kind == 2'h2)
    else $error("data out not serial");
  link_hold_a: assert property (
    o_ready |=> o_ready && $stable(o_link_kind) && $stable(o_protocol_mode))
    else $error("mode changed");
endmodule : tkpm_properties
bind tkpm_pin_mode_select tkpm_properties u_props (.*);
`default_nettype wire

// File: tb/tkpm_host_model.sv
`default_nettype none
module tkpm_host_model (
  input wire logic [2:0] i_strap,
  output logic o_sck,
  output logic o_sdi,
  output logic o_sdo_strap
);
  timeunit 1ns;
  timeprecision 100ps;
  logic busy = 1'h0;
  logic sck_q = 1'h0;
  logic sdi_q = 1'h0;
  // Between frames the clock stands still at the strap level.
  assign o_sck = busy ? sck_q : i_strap[0];
  assign o_sdi = busy ? sdi_q : i_strap[1];
  assign o_sdo_strap = i_strap[2];
  // Sends a byte, high bit first, at a 125 ns link clock.
  task automatic send(input logic [7:0] b);
    busy = 1'h1;
    for (int k = 7; k >= 0; k--)
    begin
      sck_q = 1'h0;
      sdi_q = b[k];
      #62.5;
      sck_q = 1'h1;
      #62.5;
    end
    busy = 1'h0;
  endtask : send
endmodule : tkpm_host_model
`default_nettype wire

// File: tb/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk = 1'h0, i_sys_rst = 1'h1, i_pin_mode_select = 1'h0, i_power_save_n = 1'h1;
  logic i_strap_means_spi = 1'h0, i_packet_pending = 1'h0, i_spi_data_out = 1'h0;
  logic i_i2c_data_drive_low = 1'h0, i_shared_as_status = 1'h0, clk_d = 1'h0;
  logic [8:0] i_touch_key_inputs = 9'h0, i_shared_key_or_status_pins = 9'h0, i_key_status = 9'h0;
  logic [2:0] strap = 3'h0;
  // Serial data bits as the core sees them, taken at each serial clock rise.
  logic [7:0] rx = 8'h00;
  logic o_packet_request_n, o_interface_select_1, o_interface_select_1_oe, o_interface_select_2;
  logic o_interface_select_2_oe, o_protocol_mode, o_sleep, o_serial_clk, o_serial_data_in, o_ready;
  logic [8:0] o_shared_key_or_status_pins, o_shared_key_or_status_pins_oe;
  logic [1:0] o_link_kind;
  logic [2:0] o_direct_mode_code;
  logic [17:0] o_keys;
  wire logic i_interface_select_0, sdi, sdo_s;
  // The open-drain data line is low whenever the block pulls it.
  wire logic i_interface_select_1 = o_interface_select_1_oe ? 1'h0 : sdi;
  wire logic i_interface_select_2 = o_interface_select_2_oe ? o_interface_select_2 : sdo_s;
  int error_cnt = 0, n_tests = 0, cyc = 0, edges = 0, e0;
  tkpm_pin_mode_select dut (.*);
  tkpm_host_model host (.i_strap(strap), .o_sck(i_interface_select_0), .o_sdi(sdi),
    .o_sdo_strap(sdo_s));
  initial
  begin
    forever #5 i_clk = ~i_clk;
  end
  // Counts serial clock rises seen by the core; a hang ends the run.
  always @(posedge i_clk)
  begin
    clk_d <= o_serial_clk;
    // Gated by reset so the unknown level before the first edge is never counted.
    if (!i_sys_rst && o_serial_clk && !clk_d)
    begin
      edges <= edges + 1;
      rx <= {rx[6:0], o_serial_data_in};
    end
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [17:0] seen, input logic [17:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("FAIL %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic w(input int n);
    repeat (n) @(negedge i_clk);
  endtask : w
  // Straps stay put from release on; capture and ready land within 20 edges.
  task automatic boot(input logic m, input logic s, input logic [2:0] st);
    i_sys_rst = 1'h1;
    i_pin_mode_select = m;
    i_strap_means_spi = s;
    strap = st;
    w(3);
    i_sys_rst = 1'h0;
    w(20);
    chk("ready", o_ready, 18'h1);
    chk("protocol", o_protocol_mode, {17'h0, !m});
  endtask : boot
  task automatic end_sim();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  initial
  begin
    @(negedge i_clk);
    boot(1'h0, 1'h1, 3'h0);
    chk("link", o_link_kind, 18'h2);
    i_spi_data_out = 1'h1;
    w(2);
    chk("sdo", {o_interface_select_2_oe, o_interface_select_2}, 18'h3);
    i_packet_pending = 1'h1;
    w(2);
    chk("req", o_packet_request_n, 18'h0);
    i_packet_pending = 1'h0;
    w(2);
    chk("req", o_packet_request_n, 18'h1);
    i_power_save_n = 1'h0;
    w(8);
    chk("sleep", o_sleep, 18'h1);
    i_power_save_n = 1'h1;
    w(8);
    chk("sleep", o_sleep, 18'h0);
    e0 = edges;
    host.send(8'hA5);
    w(8);
    chk("sck", 18'(edges - e0), 18'h8);
    chk("sdi", {10'h000, rx}, 18'h000A5);
    i_pin_mode_select = 1'h1;
    i_strap_means_spi = 1'h0;
    w(20);
    chk("hold", {o_protocol_mode, o_link_kind}, 18'h6);
    $display("test spi done");
    boot(1'h0, 1'h0, 3'h0);
    chk("link", o_link_kind, 18'h1);
    i_i2c_data_drive_low = 1'h1;
    w(2);
    chk("sda", {o_interface_select_1_oe, o_interface_select_2_oe}, 18'h2);
    i_i2c_data_drive_low = 1'h0;
    $display("test i2c done");
    boot(1'h1, 1'h0, 3'h5);
    chk("code", o_direct_mode_code, 18'h5);
    chk("idle", {o_serial_clk, o_serial_data_in}, 18'h3);
    i_packet_pending = 1'h1;
    i_touch_key_inputs = 9'h1A5;
    i_shared_key_or_status_pins = 9'h0C3;
    w(8);
    chk("req", o_packet_request_n, 18'h1);
    chk("keys", o_keys, {9'h0C3, 9'h1A5});
    i_shared_as_status = 1'h1;
    i_key_status = 9'h15A;
    w(8);
    chk("stat", {o_shared_key_or_status_pins_oe, o_shared_key_or_status_pins}, 18'h3FF5A);
    chk("keys", o_keys, 18'h1A5);
    $display("test direct done");
    end_sim();
  end
endmodule : tb
`default_nettype wire
